// ===== serial_port_pkg.sv
// Shared constants of the serial control port and its word buffer.
// Assumes nothing beyond a SystemVerilog compiler.
package serial_port_pkg;
  localparam int WORD_BITS = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_BITS = 5;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CNT_SAT = 5'h11;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [2:0] SYNC_RESET = 3'h7;
  localparam logic [2:0] CLK_SYNC_RESET = 3'h0;
endpackage

// ===== word_fifo.sv
// Word buffer between the serial port and the control logic.
// Assumes both sides run on the one system clock.
`timescale 1ns/100ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_C = DEPTH[PW:0];

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] cnt_reg;
  logic push;
  logic pop;

  // Output stage is a register, so the top sees valid and data from a flop
  assign in_ready = (cnt_reg != DEPTH_C);
  assign push = in_valid && in_ready;
  assign pop = (cnt_reg != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr_reg];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

// ===== serial_control_port.sv
// Serial control port: 16-bit words in, status out, words buffered for the core.
// Assumes the select, clock and data pins are asynchronous to CLK_SYS and
// that the serial clock is far slower than CLK_SYS (it is sampled here).
`timescale 1ns/100ps
module serial_control_port (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic SELECT_LOW_IN,
  input wire logic SCLK_IN,
  input wire logic SDI_IN,
  output logic SDO_OUT,
  output logic SDO_OE,
  input wire logic [15:0] STATUS_IN,
  output logic CTRL_VALID,
  input wire logic CTRL_READY,
  output logic [15:0] CTRL_WORD,
  output logic FRAME_ERR,
  output logic OVERRUN
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [2:0] sel_sync_reg;
  logic [2:0] clk_sync_reg;
  logic [1:0] sdi_sync_reg;

  // Stage 0 feeds only stage 1; edges are found between stages 1 and 2
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sel_sync_reg <= serial_port_pkg::SYNC_RESET;
      clk_sync_reg <= serial_port_pkg::CLK_SYNC_RESET;
      sdi_sync_reg <= 2'h0;
    end else begin
      sel_sync_reg <= {sel_sync_reg[1:0], SELECT_LOW_IN};
      clk_sync_reg <= {clk_sync_reg[1:0], SCLK_IN};
      sdi_sync_reg <= {sdi_sync_reg[0], SDI_IN};
    end
  end

  logic selected;
  logic sel_fall;
  logic sel_rise;
  logic sclk_fall;
  logic sclk_rise;
  logic sdi_s;

  assign selected = !sel_sync_reg[1];
  assign sel_fall = sel_sync_reg[2] && !sel_sync_reg[1];
  assign sel_rise = !sel_sync_reg[2] && sel_sync_reg[1];
  // Clock edges count only inside a selection; glitches outside are ignored
  assign sclk_fall = selected && !sel_fall && clk_sync_reg[2] && !clk_sync_reg[1];
  assign sclk_rise = selected && !sel_fall && !clk_sync_reg[2] && clk_sync_reg[1];
  assign sdi_s = sdi_sync_reg[1];

  // ************************************************************
  // Receive shifter
  // ************************************************************
  logic [15:0] rx_shift_reg;
  logic [serial_port_pkg::CNT_BITS-1:0] bit_cnt_reg;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rx_shift_reg <= serial_port_pkg::WORD_RESET;
      bit_cnt_reg <= '0;
    end else if (sel_fall) begin
      bit_cnt_reg <= '0;
    end else if (sclk_fall) begin
      // First bit ends up in bit 0 after sixteen shifts
      rx_shift_reg <= {sdi_s, rx_shift_reg[15:1]};
      // Saturate so an overlong frame never wraps back to sixteen
      if (bit_cnt_reg != serial_port_pkg::CNT_SAT) begin
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
      end
    end
  end

  // ************************************************************
  // Transmit shifter and output driver
  // ************************************************************
  logic [15:0] tx_shift_reg;

  // Bits change on the rising edge so they stand across the falling one
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      tx_shift_reg <= serial_port_pkg::WORD_RESET;
      SDO_OUT <= 1'b0;
      SDO_OE <= 1'b0;
    end else if (sel_fall) begin
      tx_shift_reg <= STATUS_IN;
      SDO_OUT <= STATUS_IN[0];
      SDO_OE <= 1'b1;
    end else if (!selected) begin
      SDO_OUT <= 1'b0;
      SDO_OE <= 1'b0;
    end else if (sclk_rise) begin
      SDO_OUT <= tx_shift_reg[0];
      tx_shift_reg <= {1'b0, tx_shift_reg[15:1]};
    end
  end

  // ************************************************************
  // Frame end and word buffer
  // ************************************************************
  logic push_reg;
  logic [15:0] push_word_reg;
  logic fifo_ready;
  logic frame_ok;

  // Words are held back until select rises, so a partial frame never acts
  assign frame_ok = (bit_cnt_reg == serial_port_pkg::FRAME_BITS);

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      push_reg <= 1'b0;
      push_word_reg <= serial_port_pkg::WORD_RESET;
      FRAME_ERR <= 1'b0;
      OVERRUN <= 1'b0;
    end else begin
      push_reg <= sel_rise && frame_ok && fifo_ready;
      FRAME_ERR <= sel_rise && !frame_ok;
      // A full buffer drops the new word rather than stall the link
      OVERRUN <= sel_rise && frame_ok && !fifo_ready;
      if (sel_rise) begin
        push_word_reg <= rx_shift_reg;
      end
    end
  end

  word_fifo #(
    .WIDTH(serial_port_pkg::WORD_BITS),
    .DEPTH(serial_port_pkg::FIFO_DEPTH)
  ) u_word_fifo (
    .clk(CLK_SYS),
    .rst(RST),
    .in_valid(push_reg),
    .in_ready(fifo_ready),
    .in_data(push_word_reg),
    .out_valid(CTRL_VALID),
    .out_ready(CTRL_READY),
    .out_data(CTRL_WORD)
  );
endmodule

// ===== serial_control_port_properties.sv
// Concurrent checks on the serial control port pins.
// Assumes it is bound onto serial_control_port.
`timescale 1ns/100ps
module scp_properties (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic SELECT_LOW_IN,
  input wire logic SDO_OUT,
  input wire logic SDO_OE,
  input wire logic CTRL_VALID,
  input wire logic CTRL_READY,
  input wire logic [15:0] CTRL_WORD,
  input wire logic FRAME_ERR,
  input wire logic OVERRUN
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // Four settled cycles leave room for the pin synchroniser
  sequence sel_held;
    $fell(SELECT_LOW_IN) ##1 !SELECT_LOW_IN [*4];
  endsequence
  a_oe_on_sel: assert property (sel_held |-> SDO_OE) else $error("sdo not driven");
  a_oe_off_idle: assert property (SELECT_LOW_IN [*5] |-> !SDO_OE) else $error("sdo driven");
  a_sdo_off_low: assert property (!SDO_OE |-> !SDO_OUT) else $error("sdo not low");
  a_err_one_pulse: assert property (FRAME_ERR |=> !FRAME_ERR) else $error("err too long");
  a_err_at_end: assert property (FRAME_ERR |-> $past(SELECT_LOW_IN, 2)) else $error("early err");
  a_err_ovr_excl: assert property (!(FRAME_ERR && OVERRUN)) else $error("err and overrun");
  a_word_held: assert property (CTRL_VALID && !CTRL_READY |=> CTRL_VALID && $stable(CTRL_WORD))
    else $error("word lost");
endmodule

// ===== spi_controller_model.sv
// Behavioural serial controller driving the link pins.
// Assumes an 800 ns link clock and pulled-down data idle.
`timescale 1ns/100ps
module spi_controller_model (
  output logic sel_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  logic [15:0] rx;
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // Data changes just after the rise, so a rising-edge sampler would read the old bit
  task automatic frame(input logic [15:0] w, input int n);
    sel_n = 1'b0;
    #800;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      #50 sdi = w[i];
      #350 sclk = 1'b0;
      rx = {sdo, rx[15:1]};
      #400;
    end
    sdi = 1'b0;
    #400 sel_n = 1'b1;
    #800;
  endtask
endmodule

// ===== serial_control_port_bench.sv
// Self-checking bench of the serial control port.
// Assumes the controller model drives the link pins.
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error %0t %h %h", $time, a, e); end end
module serial_control_port_bench;
  logic clk = 1'b0, rst = 1'b1, rdy = 1'b0, ferr_seen, ovr_seen;
  logic sel_n, sclk, sdi, sdo, oe, vld, ferr, ovr;
  logic [15:0] stat = 16'h0000, word;
  int n_mismatch = 0, check_count = 0;
  logic [31:0] rows [4] = '{32'h0001_8000, 32'h8000_0001, 32'ha5c3_3c5a, 32'hffff_0000};
  always #50 clk = ~clk;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ferr_seen <= 1'b0;
      ovr_seen <= 1'b0;
    end else begin
      ferr_seen <= ferr_seen | ferr;
      ovr_seen <= ovr_seen | ovr;
    end
  end
  spi_controller_model m (.sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(oe ? sdo : ~sdo));
  serial_control_port DUT (.CLK_SYS(clk), .RST(rst), .SELECT_LOW_IN(sel_n), .SCLK_IN(sclk),
    .SDI_IN(sdi), .SDO_OUT(sdo), .SDO_OE(oe), .STATUS_IN(stat), .CTRL_VALID(vld),
    .CTRL_READY(rdy), .CTRL_WORD(word), .FRAME_ERR(ferr), .OVERRUN(ovr));
  task automatic pop;
    @(negedge clk) rdy = 1'b1;
    @(negedge clk) rdy = 0;
  endtask
  task automatic end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    `CHK({oe, vld}, 2'h0)
    repeat (4) @(negedge clk);
    for (int i = 0; i < 4; i++) begin
      stat = rows[i][15:0];
      m.frame(rows[i][31:16], 16);
      `CHK(m.rx, rows[i][15:0])
      `CHK(word, rows[i][31:16])
      `CHK(vld, 1'b1)
      pop();
    end
    m.frame(16'h00ff, 15);
    `CHK({ferr_seen, vld}, 2'h2)
    // Sixteen buffered plus the output stage, so the eighteenth is dropped
    for (int i = 0; i < 18; i++) m.frame(16'(i), 16);
    `CHK(ovr_seen, 1'b1)
    for (int i = 0; i < 17; i++) begin
      `CHK(word, 16'(i))
      pop();
    end
    @(negedge clk);
    `CHK(vld, 1'b0)
    end_sim();
  end
endmodule
bind serial_control_port scp_properties u_chk (.CLK_SYS(CLK_SYS), .RST(RST),
  .SELECT_LOW_IN(SELECT_LOW_IN), .SDO_OUT(SDO_OUT), .SDO_OE(SDO_OE), .CTRL_VALID(CTRL_VALID),
  .CTRL_READY(CTRL_READY), .CTRL_WORD(CTRL_WORD), .FRAME_ERR(FRAME_ERR), .OVERRUN(OVERRUN));
